// file: fx_front_panel_controller.sv
// front-panel controller for the console effects processor
`timescale 1ns/1ps
`default_nettype none
module fx_front_panel_controller
   import fx_panel_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tempo_button,
   input wire logic store_button,
   input wire logic footswitch,
   input wire logic selector_a,
   input wire logic selector_b,
   input wire logic [KNOB_W-1:0] knob_one,
   input wire logic [KNOB_W-1:0] knob_two,
   input wire logic [KNOB_W-1:0] knob_three,
   input wire logic input_overload,
   input wire logic processed_overload,
   input wire logic signal_detect,
   output logic bank_a_led,
   output logic bank_b_led,
   output logic tempo_led,
   output logic store_led,
   output logic knob_one_match_led,
   output logic knob_two_match_led,
   output logic knob_three_match_led,
   output logic clip_led,
   output logic signal_present_led,
   output logic effects_mute,
   output logic pre_fade_listen_enable,
   output logic effects_to_aux_send_one_enable,
   output logic [4:0] program_index,
   output logic program_loading,
   output logic [TEMPO_W-1:0] delay_time_ms,
   output logic delay_beat,
   output logic [KNOB_W-1:0] param_one,
   output logic [KNOB_W-1:0] param_two,
   output logic [KNOB_W-1:0] param_three,
   output logic irq
);

   typedef struct packed {
      logic [15:0] tick_cnt;
      logic tick;
      logic boot;
      logic bank;
      logic [3:0] pos;
      logic muted;
      logic fs_enable;
      logic load_busy;
      logic [9:0] load_ms;
      logic [2:0][KNOB_W-1:0] loaded;
      logic [TEMPO_W-1:0] tempo_ms;
      logic tap_armed;
      logic [TEMPO_W-1:0] tap_ms;
      logic [TEMPO_W-1:0] beat_ms;
      store_state_type store_st;
      logic [11:0] store_ms;
      logic store_fired;
      logic [7:0] fast_ms;
      logic fast_blink;
      logic [7:0] slow_ms;
      logic slow_blink;
      logic bank_a_led;
      logic bank_b_led;
      logic tempo_led;
      logic store_led;
      logic [2:0] match;
      logic clip_led;
      logic sp_led;
      logic mute_out;
      logic pfl_en;
      logic aux_en;
      logic beat;
      logic [2:0][KNOB_W-1:0] param;
      logic [NUM_EV-1:0] irq_status;
      logic [NUM_EV-1:0] irq_en;
      logic irq;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [PROG_W-1:0] prog_mem [NUM_PROGS];
   logic mem_we;
   logic [4:0] cur_index;
   logic [PROG_W-1:0] cur_prog;
   logic [4:0] deb_raw;
   logic [4:0] deb_level;
   logic [4:0] deb_press;
   logic step_up;
   logic step_dn;
   logic [2:0][KNOB_W-1:0] knobs;

   // ==========================================================
   // debounced panel contacts
   assign deb_raw = {selector_b, selector_a, footswitch, store_button, tempo_button};

   for (genvar i = 0; i < 5; i++) begin : g_deb
      input_debouncer #(.STABLE_MS(DEBOUNCE_MS)) u_deb (
         .pclk(pclk),
         .presetn(presetn),
         .tick_en(s_q.tick),
         .raw(deb_raw[i]),
         .level(deb_level[i]),
         .press(deb_press[i])
      );
   end

   assign step_up = deb_press[3] && !deb_level[4];
   assign step_dn = deb_press[3] && deb_level[4];
   assign knobs = {knob_three, knob_two, knob_one};
   assign cur_index = {s_q.bank, s_q.pos};
   assign cur_prog = prog_mem[cur_index];

   // ==========================================================
   // next state
   always_comb begin
      logic [NUM_EV-1:0] ev;
      logic [NUM_EV-1:0] clr;
      ev = '0;
      clr = '0;
      mem_we = 1'b0;
      s_d = s_q;
      // millisecond enable
      s_d.tick = 1'b0;
      if (s_q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
         s_d.tick_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
      end
      // blink generators
      if (s_q.tick) begin
         s_d.fast_ms = s_q.fast_ms + 8'h01;
         if (s_q.fast_ms == 8'(STORE_FLASH_MS - 1)) begin
            s_d.fast_ms = '0;
            s_d.fast_blink = !s_q.fast_blink;
         end
         s_d.slow_ms = s_q.slow_ms + 8'h01;
         if (s_q.slow_ms == 8'(MUTE_FLASH_MS - 1)) begin
            s_d.slow_ms = '0;
            s_d.slow_blink = !s_q.slow_blink;
         end
      end
      // selector and bank
      if (step_up || step_dn) begin
         s_d.pos = step_up ? s_q.pos + 4'h1 : s_q.pos - 4'h1;
         if (!s_q.boot && ((step_up && s_q.pos == 4'hf) || (step_dn && s_q.pos == 4'h0))) begin
            s_d.bank = !s_q.bank;
         end
         s_d.load_busy = 1'b1;
         s_d.load_ms = '0;
      end else if (s_q.load_busy && s_q.tick) begin
         s_d.load_ms = s_q.load_ms + 10'h001;
         if (s_q.load_ms == 10'(LOAD_MS - 1)) begin
            s_d.load_busy = 1'b0;
            s_d.boot = 1'b0;
            s_d.loaded = cur_prog[3*KNOB_W-1:0];
            s_d.tempo_ms = cur_prog[PROG_W-1:3*KNOB_W];
            s_d.beat_ms = '0;
            ev[EV_LOAD_DONE] = 1'b1;
         end
      end
      // footswitch mute
      if (deb_press[2] && s_q.fs_enable) begin
         s_d.muted = !s_q.muted;
         ev[EV_MUTE] = 1'b1;
      end
      // tap tempo
      if (s_q.tap_armed && s_q.tick) begin
         s_d.tap_ms = s_q.tap_ms + 13'h0001;
         if (s_q.tap_ms == 13'(TEMPO_MAX_MS - 1)) begin
            s_d.tap_armed = 1'b0;
         end
      end
      if (deb_press[0]) begin
         if (!s_q.tap_armed) begin
            s_d.tap_armed = 1'b1;
            s_d.tap_ms = '0;
         end else if (s_q.tap_ms != '0) begin
            s_d.tempo_ms = s_q.tap_ms;
            s_d.tap_armed = 1'b0;
            s_d.beat_ms = '0;
            ev[EV_TEMPO] = 1'b1;
         end
      end
      s_d.beat = 1'b0;
      if (s_q.tick && !(deb_press[0] && s_q.tap_armed)) begin
         if (s_q.beat_ms >= s_q.tempo_ms - 13'h0001) begin
            s_d.beat_ms = '0;
            s_d.beat = 1'b1;
         end else begin
            s_d.beat_ms = s_q.beat_ms + 13'h0001;
         end
      end
      // store sequence
      if (!deb_level[1]) begin
         s_d.store_fired = 1'b0;
      end
      case (s_q.store_st)
         ST_IDLE: begin
            if (deb_level[1] && !s_q.store_fired && !s_q.load_busy) begin
               s_d.store_st = ST_HOLD;
               s_d.store_ms = '0;
            end
         end
         ST_HOLD: begin
            if (!deb_level[1]) begin
               s_d.store_st = ST_IDLE;
            end else if (s_q.tick) begin
               s_d.store_ms = s_q.store_ms + 12'h001;
               if (s_q.store_ms == 12'(STORE_HOLD_MS - 1)) begin
                  mem_we = 1'b1;
                  s_d.loaded = knobs;
                  s_d.store_fired = 1'b1;
                  s_d.store_st = ST_WRITE;
                  s_d.store_ms = '0;
               end
            end
         end
         ST_WRITE: begin
            if (s_q.tick) begin
               s_d.store_ms = s_q.store_ms + 12'h001;
               if (s_q.store_ms == 12'(STORE_BUSY_MS - 1)) begin
                  s_d.store_st = ST_DONE;
                  s_d.store_ms = '0;
               end
            end
         end
         ST_DONE: begin
            if (s_q.tick) begin
               s_d.store_ms = s_q.store_ms + 12'h001;
               if (s_q.store_ms == 12'(STORE_DONE_MS - 1)) begin
                  s_d.store_st = ST_IDLE;
                  ev[EV_STORE_DONE] = 1'b1;
               end
            end
         end
         default: begin
            s_d.store_st = ST_IDLE;
         end
      endcase
      // indicators and audio controls
      s_d.bank_a_led = !s_d.bank && (!s_d.muted || s_q.slow_blink);
      s_d.bank_b_led = s_d.bank && (!s_d.muted || s_q.slow_blink);
      s_d.tempo_led = s_d.beat_ms < 13'(TEMPO_LED_ON_MS);
      s_d.store_led = (s_d.store_st == ST_WRITE) ? s_q.fast_blink
                    : (s_d.store_st == ST_DONE);
      for (int k = 0; k < 3; k++) begin
         s_d.match[k] = knobs[k] == s_d.loaded[k];
         s_d.param[k] = knobs[k];
      end
      s_d.clip_led = input_overload || processed_overload;
      ev[EV_CLIP] = s_d.clip_led && !s_q.clip_led;
      s_d.sp_led = signal_detect;
      s_d.mute_out = s_d.muted;
      s_d.pfl_en = 1'b1;
      s_d.aux_en = 1'b1;
      // register bus
      s_d.pready = 1'b0;
      if (psel && !penable) begin
         s_d.pready = 1'b1;
         s_d.pslverr = 1'b0;
         s_d.prdata = '0;
         case (paddr)
            REG_STATUS: begin
               s_d.prdata[STAT_BANK] = s_q.bank;
               s_d.prdata[STAT_POS+:4] = s_q.pos;
               s_d.prdata[STAT_MUTED] = s_q.muted;
               s_d.prdata[STAT_LOADING] = s_q.load_busy;
               s_d.prdata[STAT_STORING] = s_q.store_st[2] || s_q.store_st[3];
               s_d.prdata[STAT_MATCH+:3] = s_q.match;
            end
            REG_TEMPO: s_d.prdata[TEMPO_W-1:0] = s_q.tempo_ms;
            REG_IRQ_STATUS: s_d.prdata[NUM_EV-1:0] = s_q.irq_status;
            REG_IRQ_CLEAR: s_d.prdata = '0;
            REG_IRQ_ENABLE: s_d.prdata[NUM_EV-1:0] = s_q.irq_en;
            REG_CONTROL: s_d.prdata[CTRL_FS_ENABLE] = s_q.fs_enable;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && s_q.pready && pwrite) begin
         case (paddr)
            REG_IRQ_CLEAR: clr = pwdata[NUM_EV-1:0];
            REG_IRQ_ENABLE: s_d.irq_en = pwdata[NUM_EV-1:0];
            REG_CONTROL: s_d.fs_enable = pwdata[CTRL_FS_ENABLE];
            default: s_d.irq_en = s_d.irq_en;
         endcase
      end
      s_d.irq_status = (s_q.irq_status & ~clr) | ev;
      s_d.irq = |(s_d.irq_status & s_d.irq_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.boot <= 1'b1;
         s_q.load_busy <= 1'b1;
         s_q.fs_enable <= CTRL_FS_ENABLE_RST;
         s_q.tempo_ms <= TEMPO_RESET_MS;
         s_q.store_st <= ST_IDLE;
         s_q.bank_a_led <= 1'b1;
         s_q.pfl_en <= 1'b1;
         s_q.aux_en <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // program memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int m = 0; m < NUM_PROGS; m++) begin
            prog_mem[m] <= {TEMPO_RESET_MS, {3 * KNOB_W{1'b0}}};
         end
      end else if (mem_we) begin
         prog_mem[cur_index] <= {s_q.tempo_ms, knobs};
      end
   end

   // ==========================================================
   // outputs
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign bank_a_led = s_q.bank_a_led;
   assign bank_b_led = s_q.bank_b_led;
   assign tempo_led = s_q.tempo_led;
   assign store_led = s_q.store_led;
   assign knob_one_match_led = s_q.match[0];
   assign knob_two_match_led = s_q.match[1];
   assign knob_three_match_led = s_q.match[2];
   assign clip_led = s_q.clip_led;
   assign signal_present_led = s_q.sp_led;
   assign effects_mute = s_q.mute_out;
   assign pre_fade_listen_enable = s_q.pfl_en;
   assign effects_to_aux_send_one_enable = s_q.aux_en;
   assign program_index = cur_index;
   assign program_loading = s_q.load_busy;
   assign delay_time_ms = s_q.tempo_ms;
   assign delay_beat = s_q.beat;
   assign param_one = s_q.param[0];
   assign param_two = s_q.param[1];
   assign param_three = s_q.param[2];
   assign irq = s_q.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   boot_bank_a_a: assert property (s_q.boot |-> !s_q.bank)
      else $error("bank B active before first load");
   bank_wrap_a: assert property (step_up && s_q.pos == 4'hf && !s_q.boot
      |=> s_q.bank != $past(s_q.bank) && s_q.pos == 4'h0)
      else $error("bank not toggled on wrap");
   bank_led_one_a: assert property (!(bank_a_led && bank_b_led))
      else $error("both bank LEDs lit");
   mute_flash_a: assert property (!s_q.muted ##1 !s_q.muted |-> bank_a_led != s_q.bank)
      else $error("bank LED wrong while unmuted");
   load_start_a: assert property ((step_up || step_dn) |=> program_loading && s_q.load_ms == '0)
      else $error("load not started on new position");
   load_end_a: assert property (s_q.load_busy && s_q.tick && !(step_up || step_dn)
      && s_q.load_ms == 10'(LOAD_MS - 1) |=> !program_loading)
      else $error("load did not end after one second");
   tempo_set_a: assert property (deb_press[0] && s_q.tap_armed && s_q.tap_ms != '0
      |=> delay_time_ms == $past(s_q.tap_ms))
      else $error("tempo not taken from tap interval");
   store_write_a: assert property (mem_we |-> s_q.store_st == ST_HOLD && deb_level[1]
      && s_q.store_ms == 12'(STORE_HOLD_MS - 1))
      else $error("store written before hold time");
   store_done_led_a: assert property (s_q.store_st == ST_DONE ##1 s_q.store_st == ST_DONE
      |-> store_led)
      else $error("store LED not steady after store");
   clip_led_a: assert property ((input_overload || processed_overload) |=> clip_led)
      else $error("clip LED missed overload");
   fs_mute_a: assert property (deb_press[2] && s_q.fs_enable
      |=> s_q.muted != $past(s_q.muted) ##1 effects_mute == $past(s_q.muted))
      else $error("footswitch did not toggle mute");
   aux_live_a: assert property (pre_fade_listen_enable && effects_to_aux_send_one_enable)
      else $error("pre-fade feeds cut");
   sp_led_a: assert property (signal_detect |=> signal_present_led)
      else $error("signal-present LED missed signal");

   store_cov: cover property (s_q.store_st == ST_DONE ##1 s_q.store_st == ST_IDLE);
   wrap_cov: cover property (s_q.bank ##1 !s_q.bank);
   tempo_cov: cover property (deb_press[0] && s_q.tap_armed);

endmodule : fx_front_panel_controller
`default_nettype wire

// file: fx_panel_pkg.sv
// constants and types shared by the effects front-panel controller
package fx_panel_pkg;

   // ==========================================================
   // clock and time base
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // ==========================================================
   // program organisation
   localparam int NUM_BANKS = 2;
   localparam int PROGS_PER_BANK = 16;
   localparam int NUM_PROGS = NUM_BANKS * PROGS_PER_BANK;
   localparam int KNOB_W = 8;
   localparam int TEMPO_W = 13;
   localparam int PROG_W = TEMPO_W + 3 * KNOB_W;

   // ==========================================================
   // times in seconds and milliseconds
   localparam int LOAD_TIME_S = 1;
   localparam int LOAD_MS = LOAD_TIME_S * 1000;
   localparam int STORE_HOLD_S = 3;
   localparam int STORE_HOLD_MS = STORE_HOLD_S * 1000;
   localparam int STORE_DONE_S = 1;
   localparam int STORE_DONE_MS = STORE_DONE_S * 1000;
   localparam int STORE_BUSY_MS = 200;
   localparam int STORE_FLASH_MS = 50;
   localparam int MUTE_FLASH_MS = 250;
   localparam int TEMPO_LED_ON_MS = 50;
   localparam int TEMPO_MAX_MS = 5000;
   localparam logic [12:0] TEMPO_RESET_MS = 13'h01f4;
   localparam int DEBOUNCE_MS = 10;

   // ==========================================================
   // register map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_TEMPO = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h0c;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] REG_CONTROL = 8'h14;
   localparam int STAT_BANK = 0;
   localparam int STAT_POS = 1;
   localparam int STAT_MUTED = 5;
   localparam int STAT_LOADING = 6;
   localparam int STAT_STORING = 7;
   localparam int STAT_MATCH = 8;
   localparam int CTRL_FS_ENABLE = 0;
   localparam logic CTRL_FS_ENABLE_RST = 1'b1;
   localparam int EV_LOAD_DONE = 0;
   localparam int EV_STORE_DONE = 1;
   localparam int EV_CLIP = 2;
   localparam int EV_MUTE = 3;
   localparam int EV_TEMPO = 4;
   localparam int NUM_EV = 5;

   // ==========================================================
   // store sequence
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_HOLD  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DONE  = 4'b1000
   } store_state_type;

endpackage : fx_panel_pkg

// file: input_debouncer.sv
// synchroniser and debouncer for one panel contact
`timescale 1ns/1ps
`default_nettype none
module input_debouncer
   import fx_panel_pkg::*;
#(
   parameter int STABLE_MS = DEBOUNCE_MS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_en,
   input wire logic raw,
   output logic level,
   output logic press
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic level;
      logic [7:0] cnt;
      logic press;
   } deb_type;

   deb_type s_q;
   deb_type s_d;

   // ==========================================================
   // filter
   always_comb begin
      s_d = s_q;
      s_d.s1 = raw;
      s_d.s2 = s_q.s1;
      s_d.press = 1'b0;
      if (s_q.s2 == s_q.level) begin
         s_d.cnt = '0;
      end else if (tick_en) begin
         if (s_q.cnt == 8'(STABLE_MS - 1)) begin
            s_d.level = s_q.s2;
            s_d.press = s_q.s2;
            s_d.cnt = '0;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.level;
   assign press = s_q.press;

   press_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      press |=> !press) else $error("press pulse longer than one cycle");

endmodule : input_debouncer
`default_nettype wire

// file: panel_operator.sv
// operator model: bouncing buttons, footswitch and selector
`timescale 1ns/1ps
`default_nettype none
module panel_operator
   import fx_panel_pkg::*;
#(
   parameter int TICK = 4
) (
   input wire logic pclk,
   output logic tempo_button,
   output logic store_button,
   output logic footswitch,
   output logic selector_a,
   output logic selector_b
);
   logic [4:0] pins = '0;
   assign {selector_b, selector_a, footswitch, store_button, tempo_button} = pins;
   // =====
   // contact with bounce on make and break
   task press(input int which, input int ms);
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         pins[which] <= ~pins[which];
      end
      repeat (ms * TICK) @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         pins[which] <= ~pins[which];
      end
      repeat (2 * DEBOUNCE_MS * TICK) @(posedge pclk);
   endtask : press
   // one detent, direction on the second contact
   task step(input logic down);
      @(posedge pclk);
      pins[4] <= down;
      repeat (2 * DEBOUNCE_MS * TICK) @(posedge pclk);
      press(3, 2 * DEBOUNCE_MS);
   endtask : step
endmodule : panel_operator
`default_nettype wire

// file: fx_front_panel_controller_tb_top.sv
// self-checking bench for the effects front-panel controller
`timescale 1ns/1ps
`default_nettype none
module fx_front_panel_controller_tb_top
   import fx_panel_pkg::*;
;
   localparam int TK = 4;
   localparam int GAP = (10 + 120 * TK) / TK;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, tb_, sb_, fs_, sa_, sbb_, ps;
   logic [7:0] k1 = '0, k2 = '0, k3 = '0;
   logic iov = 0, pov = 0, sd = 0;
   logic ba, bb, tl, sl, m1, m2, m3, cl, sp, mu, pf, ax, ld, beat, irq;
   logic [4:0] pidx;
   logic [12:0] dt;
   logic [7:0] p1, p2, p3;
   int err_count = 0, samples_checked = 0, cycles = 0, n, t;
   row_type rows [6] = '{'{REG_STATUS, 32'h0000_0700, 0}, '{REG_TEMPO, 32'h0000_01f4, 0},
      '{REG_IRQ_ENABLE, 32'h0000_0000, 0}, '{REG_CONTROL, 32'h0000_0001, 0},
      '{REG_IRQ_CLEAR, 32'h0000_0000, 0}, '{8'h18, 32'h0000_0000, 1}};
   always #20 pclk = ~pclk;
   panel_operator #(.TICK(TK)) op (.pclk(pclk), .tempo_button(tb_), .store_button(sb_),
      .footswitch(fs_), .selector_a(sa_), .selector_b(sbb_));
   fx_front_panel_controller #(.TICK_CYCLES(TK)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tempo_button(tb_),
      .store_button(sb_), .footswitch(fs_), .selector_a(sa_), .selector_b(sbb_),
      .knob_one(k1), .knob_two(k2), .knob_three(k3), .input_overload(iov),
      .processed_overload(pov), .signal_detect(sd), .bank_a_led(ba), .bank_b_led(bb),
      .tempo_led(tl), .store_led(sl), .knob_one_match_led(m1), .knob_two_match_led(m2),
      .knob_three_match_led(m3), .clip_led(cl), .signal_present_led(sp), .effects_mute(mu),
      .pre_fade_listen_enable(pf), .effects_to_aux_send_one_enable(ax), .program_index(pidx),
      .program_loading(ld), .delay_time_ms(dt), .delay_beat(beat), .param_one(p1),
      .param_two(p2), .param_three(p3), .irq(irq));
   // =====
   // shared tasks
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task wait_load;
      n = 0;
      while (ld !== 1'b0 && n < 6000) begin
         @(posedge pclk);
         n++;
      end
      if (n == 6000) err_count++;
   endtask : wait_load
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         print_verdict();
      end
   end
   // =====
   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      check("bank_a", ba, 1);
      check("loading", ld, 1);
      check("tempo", dt, 13'h01f4);
      check("pfl", pf, 1);
      presetn <= 1;
      wait_load();
      check("load_time", n >= LOAD_MS * TK - 8 && n <= LOAD_MS * TK + 8, 1);
      foreach (rows[i]) begin
         apb(0, rows[i].a, 0);
         check("rdata", rd, rows[i].d);
         check("slverr", er, rows[i].e);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         {iov, pov} <= i[1:0];
         sd <= i[0];
         repeat (3) @(posedge pclk);
         check("clip", cl, i != 0);
         check("sp", sp, i[0]);
      end
      k1 <= 8'h05;
      repeat (3) @(posedge pclk);
      check("match1", m1, 0);
      check("param1", p1, 8'h05);
      apb(1, REG_IRQ_ENABLE, 32'h0000_0008);
      op.press(2, 20);
      check("mute", mu, 1);
      check("aux", ax, 1);
      check("irq", irq, 1);
      n = 0;
      repeat (2 * MUTE_FLASH_MS * TK + 4) @(posedge pclk) n += (ba === 1'b0);
      check("flash", n > 0, 1);
      check("bank_b", bb, 0);
      apb(1, REG_IRQ_CLEAR, 32'h0000_0008);
      repeat (2) @(posedge pclk);
      check("irq_clr", irq, 0);
      apb(1, REG_CONTROL, 32'h0000_0000);
      op.press(2, 20);
      check("fs_off", mu, 1);
      apb(1, REG_CONTROL, 32'h0000_0001);
      op.press(2, 20);
      check("unmute", mu, 0);
      op.press(0, 100);
      op.press(0, 100);
      repeat (5) @(posedge pclk);
      check("tap", dt >= GAP - 1 && dt <= GAP + 2, 1);
      n = 0;
      t = 0;
      repeat (3 * dt * TK) @(posedge pclk) begin
         n += (beat === 1'b1);
         t += (tl === 1'b1);
      end
      check("beats", n, 3);
      check("tempo_led", t, 3 * TEMPO_LED_ON_MS * TK);
      for (int i = 0; i < 16; i++) op.step(0);
      check("wrap_up", pidx, 5'h10);
      check("led_b", {ba, bb}, 2'b01);
      check("loading2", ld, 1);
      op.step(1);
      check("wrap_dn", pidx, 5'h0f);
      check("led_a", {ba, bb}, 2'b10);
      wait_load();
      k2 <= 8'h33;
      op.press(1, STORE_HOLD_MS + 100);
      check("stored", {m1, m2, m3}, 3'b111);
      check("param23", {p2, p3}, 16'h3300);
      t = 0;
      ps = sl;
      repeat (STORE_BUSY_MS * TK) @(posedge pclk) begin
         t += (sl !== ps);
         ps = sl;
      end
      check("store_flash", t > 0, 1);
      check("store_on", sl, 1);
      repeat ((STORE_DONE_MS + 200) * TK) @(posedge pclk);
      check("store_off", sl, 0);
      apb(0, REG_IRQ_STATUS, 0);
      check("store_ev", rd[1], 1);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      check("rst_idx", pidx, 5'h00);
      check("rst_irq", irq, 0);
      check("rst_led", {ba, bb}, 2'b10);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      check("rst_load", ld, 1);
      print_verdict();
   end
endmodule : fx_front_panel_controller_tb_top
`default_nettype wire
